/* rtl/lpm_pkg.sv */
// Package of constants and types for the low-power mode controller.
`default_nettype none
package lpm_pkg;

    // ****************************************************************
    // Operating modes
    // ****************************************************************
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_WAIT,
        MODE_PSEUDO,
        MODE_STOP
    } lpm_mode_t;

    // ****************************************************************
    // Software requests
    // ****************************************************************
    localparam logic [1:0] REQ_NONE = 2'h0;
    localparam logic [1:0] REQ_WAIT = 2'h1;
    localparam logic [1:0] REQ_STOP = 2'h2;

    // ****************************************************************
    // Reset values and widths
    // ****************************************************************
    localparam int unsigned MOD_COUNT        = 8;
    localparam int unsigned BUS_OUT_DIV_HALF = 1;
    localparam logic        CPU_RUN_RST      = 1'h1;
    localparam logic        OSC_RUN_RST      = 1'h1;

endpackage : lpm_pkg
`default_nettype wire

/* rtl/clk_gate_cell.sv */
// Latch-free clock enable cell that gives one gated clock-enable per module.
`timescale 1ns/1ns
`default_nettype none
module clk_gate_cell
    import lpm_pkg::*;
#(
    parameter int unsigned N = MOD_COUNT
)(
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         bus_on,
    input  wire logic         in_wait,
    input  wire logic [N-1:0] wait_keep,
    output var  logic [N-1:0] mod_clk_en
);

    logic [N-1:0] en_r;
    logic [N-1:0] en_nxt;

    // ****************************************************************
    // Per-module enable
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_mod
            // In wait, only modules marked to stay awake get a clock.
            always_comb
            begin
                en_nxt[g] = bus_on && (!in_wait || wait_keep[g]);
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (!rstn)
            en_r <= '1;
        else
            en_r <= en_nxt;
    end

    assign mod_clk_en = en_r;

endmodule : clk_gate_cell
`default_nettype wire

/* rtl/lpm_ctrl.sv */
// Low-power mode controller: run, wait, pseudo stop and stop.
`timescale 1ns/1ns
`default_nettype none
module lpm_ctrl
    import lpm_pkg::*;
#(
    parameter int unsigned N = MOD_COUNT
)(
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [1:0]   sw_req,
    input  wire logic         pseudo_sel,
    input  wire logic         wake,
    input  wire logic [N-1:0] wait_keep,
    output var  logic         cpu_run,
    output var  logic         bus_clk_en,
    output var  logic         osc_en,
    output var  logic         bus_clock_out,
    output var  logic [1:0]   mode,
    output var  logic [N-1:0] mod_clk_en
);

    // ****************************************************************
    // Mode state
    // ****************************************************************
    lpm_mode_t mode_r;
    lpm_mode_t mode_nxt;

    always_comb
    begin
        mode_nxt = mode_r;
        unique case (mode_r)
            MODE_RUN:
            begin
                if (sw_req == REQ_WAIT)
                    mode_nxt = MODE_WAIT;
                else if (sw_req == REQ_STOP)
                    mode_nxt = pseudo_sel ? MODE_PSEUDO : MODE_STOP;
            end
            MODE_WAIT, MODE_PSEUDO, MODE_STOP:
            begin
                if (wake)
                    mode_nxt = MODE_RUN;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            mode_r <= MODE_RUN;
        else
            mode_r <= mode_nxt;
    end

    // ****************************************************************
    // Clock and execution enables
    // ****************************************************************
    // Enables follow the next mode so they change in step with mode.
    logic cpu_r;
    logic cpu_nxt;
    logic bus_r;
    logic bus_nxt;
    logic osc_r;
    logic osc_nxt;

    always_comb
    begin
        cpu_nxt = (mode_nxt == MODE_RUN);
        bus_nxt = (mode_nxt == MODE_RUN) || (mode_nxt == MODE_WAIT);
        osc_nxt = (mode_nxt != MODE_STOP);
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            cpu_r <= CPU_RUN_RST;
            bus_r <= 1'h1;
            osc_r <= OSC_RUN_RST;
        end
        else
        begin
            cpu_r <= cpu_nxt;
            bus_r <= bus_nxt;
            osc_r <= osc_nxt;
        end
    end

    // ****************************************************************
    // Bus clock output
    // ****************************************************************
    // Divided by two from clk so it comes from a flip-flop; a stopped
    // bus clock parks the pin low rather than freezing mid-level.
    logic clk_out_r;
    logic clk_out_nxt;

    always_comb
    begin
        clk_out_nxt = bus_nxt ? ~clk_out_r : 1'h0;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            clk_out_r <= 1'h0;
        else
            clk_out_r <= clk_out_nxt;
    end

    logic [1:0] mode_out_r;

    always_ff @(posedge clk)
    begin
        if (!rstn)
            mode_out_r <= 2'h0;
        else
            mode_out_r <= mode_nxt;
    end

    clk_gate_cell #(
        .N          (N)
    ) u_gate (
        .clk        (clk),
        .rstn       (rstn),
        .bus_on     (bus_nxt),
        .in_wait    (mode_nxt == MODE_WAIT),
        .wait_keep  (wait_keep),
        .mod_clk_en (mod_clk_en)
    );

    assign cpu_run       = cpu_r;
    assign bus_clk_en    = bus_r;
    assign osc_en        = osc_r;
    assign bus_clock_out = clk_out_r;
    assign mode          = mode_out_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // ****************************************************************
    // Checks: mode entry and exit
    // ****************************************************************
    chk_wait_entry: assert property (
        mode_r == MODE_RUN && sw_req == REQ_WAIT
        |=> !cpu_run && bus_clk_en && osc_en)
        else $error("wait entry enables wrong");

    chk_pseudo_osc: assert property (
        mode_r == MODE_RUN && sw_req == REQ_STOP && pseudo_sel
        |=> !bus_clk_en && osc_en)
        else $error("pseudo stop enables wrong");

    chk_stop_osc: assert property (
        mode_r == MODE_RUN && sw_req == REQ_STOP && !pseudo_sel
        |=> !bus_clk_en && !osc_en)
        else $error("stop enables wrong");

    // Wake must bring back execution and a moving bus clock at once.
    chk_wake_run: assert property (
        mode_r != MODE_RUN && wake
        |=> cpu_run && bus_clk_en && osc_en
            && bus_clock_out != $past(bus_clock_out))
        else $error("wake did not restore run");

    // A refused or absent request must leave the device in run.
    chk_run_hold: assert property (
        mode_r == MODE_RUN && (sw_req == REQ_NONE || sw_req == 2'h3)
        |=> mode == MODE_RUN && cpu_run)
        else $error("run left without request");

    // Requests are only honoured in run, so a sleeping device stays put.
    chk_sleep_hold: assert property (
        mode_r != MODE_RUN && !wake |=> mode == $past(mode))
        else $error("low-power mode left without wake");

    // ****************************************************************
    // Checks: enables per mode
    // ****************************************************************
    chk_cpu_mode: assert property (
        cpu_run == (mode == MODE_RUN))
        else $error("cpu run flag disagrees with mode");

    chk_bus_mode: assert property (
        bus_clk_en == (mode == MODE_RUN || mode == MODE_WAIT))
        else $error("bus clock enable disagrees with mode");

    chk_osc_mode: assert property (
        osc_en == (mode != MODE_STOP))
        else $error("oscillator enable disagrees with mode");

    // ****************************************************************
    // Checks: module clock gating
    // ****************************************************************
    chk_wait_gate: assert property (
        mode_r == MODE_WAIT && !wake |=> mod_clk_en == $past(wait_keep))
        else $error("wait gating wrong");

    chk_run_gate: assert property (
        mode == MODE_RUN |-> mod_clk_en == '1)
        else $error("module clocks gated in run");

    chk_off_gate: assert property (
        !bus_clk_en |-> mod_clk_en == '0)
        else $error("module clocks run without bus clock");

    // ****************************************************************
    // Checks: bus clock output
    // ****************************************************************
    // The antecedent uses the next-state enable because the pin toggles or
    // parks on the same edge at which bus_clk_en takes that value.
    chk_clkout_toggle: assert property (
        bus_nxt |=> bus_clock_out != $past(bus_clock_out))
        else $error("bus clock output not toggling");

    chk_clkout_parked: assert property (
        !bus_clk_en |-> !bus_clock_out)
        else $error("bus clock output moves while stopped");

    // ****************************************************************
    // Cover points
    // ****************************************************************
    cov_wait: cover property (mode_r == MODE_WAIT ##1 mode_r == MODE_RUN);
    cov_pseudo: cover property (mode_r == MODE_PSEUDO ##1 mode_r == MODE_RUN);
    cov_stop: cover property (mode_r == MODE_STOP ##1 mode_r == MODE_RUN);
    cov_refused: cover property (mode_r == MODE_RUN && sw_req == 2'h3);
    cov_back_to_back: cover property (
        mode_r == MODE_PSEUDO ##1 mode_r == MODE_RUN ##1 mode_r == MODE_WAIT);

endmodule : lpm_ctrl
`default_nettype wire

/* bench/testbench.sv */
// Self-checking testbench for the low-power mode controller.
`timescale 1ns/1ns
`default_nettype none
module testbench
    import lpm_pkg::*;
;
    logic       clk        = 1'h0;
    logic       rstn       = 1'h0;
    logic [1:0] sw_req     = REQ_NONE;
    logic       pseudo_sel = 1'h0;
    logic       wake       = 1'h0;
    logic [7:0] wait_keep  = 8'hA5;
    logic       cpu_run;
    logic       bus_clk_en;
    logic       osc_en;
    logic       bus_clock_out;
    logic [1:0] mode;
    logic [7:0] mod_clk_en;
    int         fails           = 0;
    int         samples_checked = 0;
    int         cycles          = 0;

    lpm_ctrl #(.N(8)) dut (.clk(clk), .rstn(rstn), .sw_req(sw_req),
        .pseudo_sel(pseudo_sel), .wake(wake), .wait_keep(wait_keep),
        .cpu_run(cpu_run), .bus_clk_en(bus_clk_en), .osc_en(osc_en),
        .bus_clock_out(bus_clock_out), .mode(mode),
        .mod_clk_en(mod_clk_en));

    initial
    begin
        forever #10 clk = ~clk;
    end

    // ****************************************************************
    // Shared checking tasks
    // ****************************************************************
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Inputs change on the falling edge; the request is held one cycle.
    task automatic step(input logic [1:0] req, input logic ps,
                        input logic wk);
        @(negedge clk);
        sw_req = req;
        pseudo_sel = ps;
        wake = wk;
        @(negedge clk);
        sw_req = REQ_NONE;
        wake = 1'h0;
    endtask : step

    task automatic expect_state(input lpm_mode_t m);
        logic       bus;
        logic [7:0] en;
        logic [7:0] b;
        bus = (m == MODE_RUN) || (m == MODE_WAIT);
        en = !bus ? 8'h00 : (m == MODE_WAIT) ? wait_keep : 8'hFF;
        check("mode", {6'h0, mode}, {6'h0, m});
        check("cpu_run", 8'(cpu_run), 8'(m == MODE_RUN));
        check("bus_clk_en", 8'(bus_clk_en), 8'(bus));
        check("osc_en", 8'(osc_en), 8'(m != MODE_STOP));
        check("mod_clk_en", mod_clk_en, en);
        // Two falling-edge samples catch clk/2 toggling or a held low.
        b[0] = bus_clock_out;
        @(negedge clk);
        b[1] = bus_clock_out;
        check("bus_clock_out toggle", 8'(b[0] ^ b[1]), 8'(bus));
        if (!bus)
            check("bus_clock_out idle", 8'(b[1]), 8'h00);
    endtask : expect_state

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_wait();
        step(REQ_WAIT, 1'h0, 1'h0);
        expect_state(MODE_WAIT);
        wait_keep = 8'h3C;
        step(REQ_STOP, 1'h1, 1'h0);
        expect_state(MODE_WAIT);
        step(REQ_NONE, 1'h0, 1'h1);
        expect_state(MODE_RUN);
    endtask : t_wait

    task automatic t_pseudo_back_to_back();
        step(REQ_STOP, 1'h1, 1'h0);
        expect_state(MODE_PSEUDO);
        @(negedge clk);
        wake = 1'h1;
        @(negedge clk);
        wake = 1'h0;
        sw_req = REQ_WAIT;
        @(negedge clk);
        sw_req = REQ_NONE;
        expect_state(MODE_WAIT);
        step(REQ_NONE, 1'h0, 1'h1);
        expect_state(MODE_RUN);
    endtask : t_pseudo_back_to_back

    task automatic t_stop();
        step(REQ_STOP, 1'h0, 1'h0);
        expect_state(MODE_STOP);
        step(REQ_NONE, 1'h0, 1'h1);
        expect_state(MODE_RUN);
    endtask : t_stop

    task automatic t_refused();
        step(2'h3, 1'h1, 1'h0);
        expect_state(MODE_RUN);
        step(REQ_NONE, 1'h0, 1'h1);
        expect_state(MODE_RUN);
    endtask : t_refused

    // A reset taken in stop must bring the block back to a running state.
    task automatic t_reset();
        step(REQ_STOP, 1'h0, 1'h0);
        expect_state(MODE_STOP);
        rstn = 1'h0;
        repeat (2) @(negedge clk);
        rstn = 1'h1;
        @(negedge clk);
        expect_state(MODE_RUN);
    endtask : t_reset

    // ****************************************************************
    // Closing report and run control
    // ****************************************************************
    task automatic results();
        if (fails == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    // The whole run needs well under 200 cycles.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fails++;
            results();
        end
    end

    initial
    begin
        repeat (6) @(negedge clk);
        rstn = 1'h1;
        @(negedge clk);
        expect_state(MODE_RUN);
        t_wait();
        t_pseudo_back_to_back();
        t_stop();
        t_refused();
        t_reset();
        results();
    end
endmodule : testbench
`default_nettype wire
